// File: pch_pkg.sv
// Constants and types for the configuration header register slice.
// Assumes one PCI clock domain and a config port fed by the local target logic.
//
// Functional notes
// (R1) Read-only revision byte returns a chosen design revision number.
// (R2) Class code is 24 read-only bits: base, sub-class, programming interface.
// (R3) Base class byte, bits 23 to 16, always reads serial bus controller code.
// (R4) Sub-class byte, bits 15 to 8, always reads USB host controller code.
// (R5) Programming interface reads one value for full/low-speed, another for high-speed.
// (R6) Cache line size is a read/write byte counted in doublewords.
// (R7) Cache line size clears to zero on reset.
// (R8) Bus master picks memory read, read line or read multiple by line size.
// (R9) Latency timer is a read/write byte in PCI clocks, reset to zero.
// (R10) Header type bit 7 is read-only one: multi-function device.
// (R11) Header type bits 6 to 0 read-only zero: layout from offset 0x10.
// (R12) Base register bit 0 is read-only zero: memory space.
// (R13) Base register writable bits 31:12 full/low-speed, 31:8 high-speed.
// (R14) Base register places the operational registers and resets to zero.
// (R15) Configuration software sizes and programs the base register before OS hand-off.
// (R16) Writes to read-only bits and bits below the window are ignored.
package pch_pkg;

	// ----------------------------------------
	// Register byte offsets
	// ----------------------------------------
	localparam logic [7:0] OFS_REVISION = 8'h08;
	localparam logic [7:0] OFS_CLASS = 8'h09;
	localparam logic [7:0] OFS_CACHE_LINE = 8'h0c;
	localparam logic [7:0] OFS_LATENCY = 8'h0d;
	localparam logic [7:0] OFS_HEADER = 8'h0e;
	localparam logic [7:0] OFS_BAR0 = 8'h10;

	// ----------------------------------------
	// Fixed field values and reset values
	// ----------------------------------------
	localparam logic [7:0] BASE_CLASS_SERIAL = 8'h0c;
	localparam logic [7:0] SUB_CLASS_USB_HC = 8'h03;
	localparam logic [7:0] PROG_IF_FULL_SPEED = 8'h10;
	localparam logic [7:0] PROG_IF_HIGH_SPEED = 8'h20;
	localparam logic MULTI_FUNCTION = 1'h1;
	localparam logic [6:0] HEADER_LAYOUT = 7'h00;
	localparam logic [7:0] CACHE_LINE_RESET = 8'h00;
	localparam logic [7:0] LATENCY_RESET = 8'h00;
	localparam logic [31:0] BAR0_RESET = 32'h0000_0000;
	localparam logic [31:0] BAR0_MASK_FULL_SPEED = 32'hffff_f000;
	localparam logic [31:0] BAR0_MASK_HIGH_SPEED = 32'hffff_ff00;

	// ----------------------------------------
	// Master memory read commands
	// ----------------------------------------
	localparam logic [3:0] CMD_MEM_READ = 4'h6;
	localparam logic [3:0] CMD_MEM_READ_MULTIPLE = 4'hc;
	localparam logic [3:0] CMD_MEM_READ_LINE = 4'he;

	// ----------------------------------------
	// Configuration access carrier
	// ----------------------------------------
	typedef struct packed {
		logic rd;
		logic wr;
		logic [5:0] dw_addr;
		logic [3:0] byte_en;
		logic [31:0] wdata;
	} pch_cfg_req_t;

endpackage

// File: pch_config_header.sv
// Configuration header slice: revision, class code, cache line size,
// latency timer, header type and memory base register 0.
// Assumes config cycles arrive decoded from the PCI target logic on sys_clk.
`timescale 1ns/1ps
`default_nettype none

module pch_config_header #(
	parameter bit HIGH_SPEED = 1'b0,
	// Arbitrary revision value
	parameter logic [7:0] REVISION = 8'h01
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic srst,
	// Configuration access port
	input wire pch_pkg::pch_cfg_req_t cfg_req,
	output var logic cfg_ack_ff,
	output var logic [31:0] cfg_rdata_ff,
	// Bus master read command selection
	input wire logic mrd_req,
	input wire logic [7:0] mrd_len_dw,
	output var logic mrd_cmd_valid_ff,
	output var logic [3:0] mrd_cmd_ff,
	// Programmed values for the rest of the function
	output var logic [7:0] cache_line_size_ff,
	output var logic [7:0] master_latency_timer_ff,
	output var logic [31:0] memory_base_address_0_ff
);

	// ----------------------------------------
	// Helpers
	// ----------------------------------------

	// Byte-lane merge of a write into a held word
	function automatic logic [31:0] merge_bytes(input logic [31:0] old_val,
		input logic [31:0] new_val, input logic [3:0] be);
		logic [31:0] res;
		res = old_val;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				res[8*i +: 8] = new_val[8*i +: 8];
			end
		end
		return res;
	endfunction

	// ----------------------------------------
	// Fixed values and decode
	// ----------------------------------------

	// Window size differs between full/low-speed and high-speed functions
	wire logic [31:0] bar_mask = HIGH_SPEED ? pch_pkg::BAR0_MASK_HIGH_SPEED
		: pch_pkg::BAR0_MASK_FULL_SPEED; // [R13]
	wire logic [7:0] prog_if = HIGH_SPEED ? pch_pkg::PROG_IF_HIGH_SPEED
		: pch_pkg::PROG_IF_FULL_SPEED; // [R5]
	wire logic [7:0] header_layout_field = {pch_pkg::MULTI_FUNCTION,
		pch_pkg::HEADER_LAYOUT}; // [R10] [R11]
	wire logic [23:0] function_class_code = {pch_pkg::BASE_CLASS_SERIAL,
		pch_pkg::SUB_CLASS_USB_HC, prog_if}; // [R2] [R3] [R4]

	wire logic [5:0] dw_rev = pch_pkg::OFS_REVISION[7:2];
	wire logic [5:0] dw_cls = pch_pkg::OFS_CACHE_LINE[7:2];
	wire logic [5:0] dw_bar = pch_pkg::OFS_BAR0[7:2];
	wire logic hit_rev = cfg_req.dw_addr == dw_rev;
	wire logic hit_cls = cfg_req.dw_addr == dw_cls;
	wire logic hit_bar = cfg_req.dw_addr == dw_bar;
	wire logic wr_cls = cfg_req.wr && hit_cls;
	wire logic wr_bar = cfg_req.wr && hit_bar;

	// Writable lanes; header byte stays fixed, so only lanes 0 and 1 land
	wire logic [31:0] cls_word = merge_bytes({16'h0000, master_latency_timer_ff,
		cache_line_size_ff}, cfg_req.wdata, cfg_req.byte_en);
	// Bits below the window and bit 0 are masked off, so they read zero
	wire logic [31:0] bar_word = merge_bytes(memory_base_address_0_ff, cfg_req.wdata,
		cfg_req.byte_en) & bar_mask; // [R12] [R13] [R16]

	// Read mux; offsets outside this slice answer zero
	wire logic [31:0] rd_word = hit_rev ? {function_class_code, REVISION}
		: hit_cls ? {8'h00, header_layout_field, master_latency_timer_ff,
			cache_line_size_ff}
		: hit_bar ? memory_base_address_0_ff
		: 32'h0000_0000; // [R1] [R16]

	// ----------------------------------------
	// Writable registers
	// ----------------------------------------

	// Cache line size and latency timer; reset clears both
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			cache_line_size_ff <= pch_pkg::CACHE_LINE_RESET; // [R7]
			master_latency_timer_ff <= pch_pkg::LATENCY_RESET; // [R9]
		end else if (wr_cls) begin
			cache_line_size_ff <= cls_word[7:0]; // [R6]
			master_latency_timer_ff <= cls_word[15:8]; // [R9]
		end
	end

	// Base register 0: where the operational registers decode
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			memory_base_address_0_ff <= pch_pkg::BAR0_RESET; // [R14]
		end else if (wr_bar) begin
			memory_base_address_0_ff <= bar_word; // [R14] [R16]
		end
	end

	// ----------------------------------------
	// Config answer
	// ----------------------------------------

	// One cycle after every access; writes answer too so the target can close
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			cfg_ack_ff <= 1'b0;
			cfg_rdata_ff <= 32'h0000_0000;
		end else begin
			cfg_ack_ff <= cfg_req.rd || cfg_req.wr;
			cfg_rdata_ff <= cfg_req.rd ? rd_word : 32'h0000_0000;
		end
	end

	// ----------------------------------------
	// Master read command choice
	// ----------------------------------------

	// Zero line size means unknown, so only a plain read is safe
	wire logic line_known = cache_line_size_ff != 8'h00;
	wire logic [3:0] nxt_cmd = (!line_known || mrd_len_dw <= 8'h01)
		? pch_pkg::CMD_MEM_READ
		: (mrd_len_dw <= cache_line_size_ff) ? pch_pkg::CMD_MEM_READ_LINE
		: pch_pkg::CMD_MEM_READ_MULTIPLE; // [R8]

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			mrd_cmd_valid_ff <= 1'b0;
			mrd_cmd_ff <= pch_pkg::CMD_MEM_READ;
		end else begin
			mrd_cmd_valid_ff <= mrd_req;
			if (mrd_req) begin
				mrd_cmd_ff <= nxt_cmd; // [R8]
			end
		end
	end

	// ----------------------------------------
	// Assertions
	// ----------------------------------------

	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (srst);

	wire logic rd_rev = cfg_req.rd && hit_rev;
	wire logic rd_cls = cfg_req.rd && hit_cls;
	wire logic rd_bar = cfg_req.rd && hit_bar;

	// Reset leaves the writable registers at zero
	property p_reset_values;
		@(posedge sys_clk) disable iff (1'b0)
		srst |=> cache_line_size_ff == 8'h00 && master_latency_timer_ff == 8'h00
			&& memory_base_address_0_ff == 32'h0000_0000;
	endproperty
	a_reset_values: assert property (p_reset_values) else $error("reset values wrong"); // [R7] [R9] [R14]

	property p_class_read;
		rd_rev |=> cfg_ack_ff && cfg_rdata_ff[31:24] == 8'h0c && cfg_rdata_ff[23:16] == 8'h03;
	endproperty
	a_class_read: assert property (p_class_read) else $error("class code wrong"); // [R2] [R3] [R4]

	property p_prog_if;
		rd_rev |=> cfg_rdata_ff[15:8] == (HIGH_SPEED ? 8'h20 : 8'h10)
			&& cfg_rdata_ff[7:0] == REVISION;
	endproperty
	a_prog_if: assert property (p_prog_if) else $error("interface or revision wrong"); // [R1] [R5]

	property p_header_type;
		rd_cls |=> cfg_rdata_ff[23:16] == 8'h80 && cfg_rdata_ff[31:24] == 8'h00;
	endproperty
	a_header_type: assert property (p_header_type) else $error("header type wrong"); // [R10] [R11]

	// A lane 0 write lands in the line size the next cycle, back to back or not
	property p_cls_write;
		wr_cls && cfg_req.byte_en[0]
			|=> cache_line_size_ff == $past(cfg_req.wdata[7:0]);
	endproperty
	a_cls_write: assert property (p_cls_write) else $error("line size not stored"); // [R6]

	// A lane 1 write lands in the latency timer the next cycle
	property p_lt_write;
		wr_cls && cfg_req.byte_en[1]
			|=> master_latency_timer_ff == $past(cfg_req.wdata[15:8]);
	endproperty
	a_lt_write: assert property (p_lt_write) else $error("latency timer not stored"); // [R9]

	// Without a lane 0 write the line size must not move
	property p_cls_hold;
		!(wr_cls && cfg_req.byte_en[0])
			|=> $stable(cache_line_size_ff);
	endproperty
	a_cls_hold: assert property (p_cls_hold) else $error("line size changed"); // [R6] [R16]

	property p_lt_hold;
		!(wr_cls && cfg_req.byte_en[1]) |=> $stable(master_latency_timer_ff);
	endproperty
	a_lt_hold: assert property (p_lt_hold) else $error("latency timer changed"); // [R9]

	property p_bar_low;
		(memory_base_address_0_ff & ~bar_mask) == 32'h0000_0000 && !memory_base_address_0_ff[0];
	endproperty
	a_bar_low: assert property (p_bar_low) else $error("base low bits set"); // [R12] [R13] [R16]

	property p_bar_write;
		wr_bar && cfg_req.byte_en == 4'hf ##1 rd_bar |=>
			cfg_rdata_ff == ($past(cfg_req.wdata, 2) & bar_mask);
	endproperty
	a_bar_write: assert property (p_bar_write) else $error("base readback wrong"); // [R13] [R14]

	property p_cmd_plain;
		mrd_req && cache_line_size_ff == 8'h00 |=> mrd_cmd_valid_ff && mrd_cmd_ff == 4'h6;
	endproperty
	a_cmd_plain: assert property (p_cmd_plain) else $error("plain read expected"); // [R8]

	property p_cmd_multiple;
		mrd_req && cache_line_size_ff != 8'h00 && mrd_len_dw > cache_line_size_ff
			|=> mrd_cmd_ff == 4'hc;
	endproperty
	a_cmd_multiple: assert property (p_cmd_multiple) else $error("read multiple expected"); // [R8]

	// Burst that fits inside a known line asks for a line read
	property p_cmd_line;
		mrd_req && cache_line_size_ff != 8'h00 && mrd_len_dw > 8'h01
			&& mrd_len_dw <= cache_line_size_ff
			|=> mrd_cmd_valid_ff && mrd_cmd_ff == 4'he;
	endproperty
	a_cmd_line: assert property (p_cmd_line) else $error("read line expected"); // [R8]

	// Base register only moves on a write that hits it
	property p_bar_hold;
		!wr_bar
			|=> $stable(memory_base_address_0_ff);
	endproperty
	a_bar_hold: assert property (p_bar_hold) else $error("base changed unasked"); // [R14]

	// Writes to the identity dword leave every writable register alone
	property p_rev_write;
		cfg_req.wr && hit_rev
			|=> $stable(cache_line_size_ff) && $stable(master_latency_timer_ff)
			&& $stable(memory_base_address_0_ff);
	endproperty
	a_rev_write: assert property (p_rev_write) else $error("read-only write landed"); // [R16]

	// A write answers with zero data so stale read data never leaks
	property p_wr_rdata;
		cfg_req.wr
			|=> cfg_ack_ff && cfg_rdata_ff == 32'h0000_0000;
	endproperty
	a_wr_rdata: assert property (p_wr_rdata) else $error("write answered with data"); // [R16]

	// ----------------------------------------
	// Coverage of the main scenarios
	// ----------------------------------------

	// Base write followed at once by a read of it
	property p_cov_bar_rw;
		wr_bar ##1 rd_bar;
	endproperty
	c_bar_rw: cover property (p_cov_bar_rw);

	// Read line command chosen
	property p_cov_line;
		mrd_req && nxt_cmd == pch_pkg::CMD_MEM_READ_LINE;
	endproperty
	c_line: cover property (p_cov_line);

	// Read multiple command chosen
	property p_cov_multiple;
		mrd_req && nxt_cmd == pch_pkg::CMD_MEM_READ_MULTIPLE;
	endproperty
	c_multiple: cover property (p_cov_multiple);

	// Line size programmed and used by the next master read
	property p_cov_cls_use;
		wr_cls ##1 mrd_req;
	endproperty
	c_cls_use: cover property (p_cov_cls_use);

endmodule

`default_nettype wire

// File: pch_host_model.sv
// Host bridge model that issues decoded configuration cycles.
// Assumes a one-cycle request and a registered one-cycle acknowledge.
`timescale 1ns/1ps
`default_nettype none

module pch_host_model (
	// Clock
	input wire logic sys_clk,
	// Configuration port
	output var pch_pkg::pch_cfg_req_t cfg_req,
	input wire logic cfg_ack_ff,
	input wire logic [31:0] cfg_rdata_ff
);
	// ----------------------------------------
	// Access task
	// ----------------------------------------
	initial cfg_req = '0;

	// Released lines show the inverse so stale values never pass
	task automatic xfer(input logic wr, input logic [5:0] dw, input logic [3:0] be,
		input logic [31:0] wd, output logic [31:0] rd, output bit ok);
		int n;
		ok = 0;
		rd = '0;
		@(negedge sys_clk);
		cfg_req = '{rd: !wr, wr: wr, dw_addr: dw, byte_en: be, wdata: wd};
		@(negedge sys_clk);
		cfg_req = '{rd: 1'b0, wr: 1'b0, dw_addr: ~dw, byte_en: ~be, wdata: ~wd};
		for (n = 0; n < 4; n++) begin
			if (cfg_ack_ff === 1'b1) begin
				rd = cfg_rdata_ff;
				ok = 1;
				break;
			end
			@(negedge sys_clk);
		end
	endtask
endmodule

`default_nettype wire

// File: testbench.sv
// Self-checking bench for the configuration header slice.
// Assumes the full/low-speed variant and the host bridge model.
`timescale 1ns/1ps
`default_nettype none

module testbench;
	logic sys_clk, srst, mrd_req, cfg_ack_ff, mrd_cmd_valid_ff, ok;
	logic [7:0] mrd_len_dw, cache_line_size, lt, cls_o, lt_o;
	logic [31:0] cfg_rdata_ff, bar, bar_o, rv, w;
	logic [3:0] mrd_cmd_ff, be;
	pch_pkg::pch_cfg_req_t cfg_req;
	int err_total, checked;
	localparam logic [7:0] REV = 8'h5a; // Arbitrary revision value

	pch_config_header #(.HIGH_SPEED(1'b0), .REVISION(REV)) i_pch_config_header (
		.sys_clk(sys_clk), .srst(srst), .cfg_req(cfg_req), .cfg_ack_ff(cfg_ack_ff),
		.cfg_rdata_ff(cfg_rdata_ff), .mrd_req(mrd_req), .mrd_len_dw(mrd_len_dw),
		.mrd_cmd_valid_ff(mrd_cmd_valid_ff), .mrd_cmd_ff(mrd_cmd_ff),
		.cache_line_size_ff(cls_o), .master_latency_timer_ff(lt_o),
		.memory_base_address_0_ff(bar_o));
	pch_host_model i_pch_host_model (.sys_clk(sys_clk), .cfg_req(cfg_req),
		.cfg_ack_ff(cfg_ack_ff), .cfg_rdata_ff(cfg_rdata_ff));

	initial begin
		sys_clk = 0;
		forever #4 sys_clk = ~sys_clk;
	end

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", checked, err_total);
		if (err_total == 0 && checked > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			err_total++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask

	// A lost acknowledge ends the run
	task automatic cfg(input logic wr, input logic [5:0] dw, input logic [3:0] b,
		input logic [31:0] wd);
		i_pch_host_model.xfer(wr, dw, b, wd, rv, ok);
		if (!ok) begin
			err_total++;
			print_verdict();
		end
	endtask

	function automatic logic [3:0] exp_cmd(input logic [7:0] c, input logic [7:0] n);
		if (c == 0 || n <= 1) return pch_pkg::CMD_MEM_READ;
		if (n <= c) return pch_pkg::CMD_MEM_READ_LINE;
		return pch_pkg::CMD_MEM_READ_MULTIPLE;
	endfunction

	// Reset held for five cycles, model state cleared with it
	task automatic do_reset();
		@(negedge sys_clk);
		srst = 1;
		repeat (5) @(negedge sys_clk);
		srst = 0;
		cache_line_size = 0;
		lt = 0;
		bar = 0;
	endtask

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		srst = 1;
		mrd_req = 0;
		mrd_len_dw = 0;
		err_total = 0;
		checked = 0;
		w = $urandom(2);
		do_reset();
		// Identity and reset values
		cfg(0, 6'h02, 4'hf, 0);
		chk(rv, {8'h0c, 8'h03, 8'h10, REV});
		cfg(0, 6'h03, 4'hf, 0);
		chk(rv, 32'h0080_0000);
		cfg(0, 6'h04, 4'hf, 0);
		chk(rv, 32'h0);
		$display("test reset values done");
		// Random lane writes, read-only places hit alongside
		for (int i = 0; i < 16; i++) begin
			w = $urandom;
			be = (i == 0) ? 4'hf : 4'($urandom);
			cfg(1, 6'h02, be, w);
			cfg(1, 6'h03, be, w);
			cfg(1, 6'h04, be, w);
			if (be[0]) cache_line_size = w[7:0];
			if (be[1]) lt = w[15:8];
			for (int k = 0; k < 4; k++) if (be[k]) bar[8*k+:8] = w[8*k+:8];
			cfg(0, 6'h03, 4'hf, 0);
			chk(rv, {8'h00, 8'h80, lt, cache_line_size});
			chk({bar_o[15:0], lt_o, cls_o}, {bar[15:12], 12'h0, lt, cache_line_size});
			cfg(0, 6'h04, 4'hf, 0);
			chk(rv, bar & 32'hffff_f000);
		end
		cfg(0, 6'h02, 4'hf, 0);
		chk(rv, {8'h0c, 8'h03, 8'h10, REV});
		$display("test register writes done");
		// Read command choice against the programmed line size
		for (int i = 0; i < 24; i++) begin
			cache_line_size = (i == 0) ? 8'h00 : 8'($urandom_range(0, 8));
			cfg(1, 6'h03, 4'h1, {24'h0, cache_line_size});
			@(negedge sys_clk);
			mrd_req = 1;
			mrd_len_dw = (i == 1) ? 8'h01 : 8'($urandom_range(0, 10));
			@(negedge sys_clk);
			mrd_req = 0;
			chk({31'h0, mrd_cmd_valid_ff}, 32'h1);
			chk({28'h0, mrd_cmd_ff}, {28'h0, exp_cmd(cache_line_size, mrd_len_dw)});
		end
		$display("test read commands done");
		// Reset in mid-run clears the writable registers
		do_reset();
		chk({bar_o[31:16], lt_o, cls_o}, 32'h0);
		chk({28'h0, mrd_cmd_ff}, {28'h0, pch_pkg::CMD_MEM_READ});
		$display("test second reset done");
		print_verdict();
	end
endmodule

`default_nettype wire
